// ---- common/regulator_output_control_pkg.sv ----
/*
 * Constants and carrier types for the converter output control register bank.
 * Assumes a single clock domain and a simple synchronous register port driven
 * by the serial host bus front end, which lives outside this bank.
 */
// Notes on behaviour
// [R1] Three-bit peak current limit at bits five to three.
// [R2] Current limit writes apply at once while running.
// [R3] Three-bit slew select at bits two to zero.
// [R4] Limit and slew register resets to 0x1a.
// [R5] Host never writes voltage codes below 0x14.
// [R6] Codes 0x14 to 0x17 decode in 10 mV steps.
// [R7] Codes 0x18 to 0x9d decode in 5 mV steps.
// [R8] Codes 0x9e to 0xff decode in 20 mV steps.
// [R9] Separate voltage field per converter, same mapping.
// [R10] Boost voltage field at bits seven to six.
// [R11] Discharge resistor connects while boost disabled if set.
// [R12] Pin select gates boost enable with chosen pin.
// [R13] Bit zero is the boost enable request.
// [R14] Boost control register resets to 0x08.
// [R15] Voltage code registers reset to zero, then load stored defaults.
// [R16] Combined enable edges time startup and shutdown delays.
// [R17] Enable pins are synchronised before being combined.
// [R18] Host avoids reserved codes, keeps reserved bits.
package regulator_output_control_pkg;

    // Register offsets on the register port.
    localparam logic [7:0] OFS_STEPDOWN1_LIMIT_AND_SLEW = 8'h05;
    localparam logic [7:0] OFS_STEPDOWN0_VOLTAGE_CODE = 8'h06;
    localparam logic [7:0] OFS_STEPDOWN1_VOLTAGE_CODE = 8'h07;
    localparam logic [7:0] OFS_BOOSTER_CONTROL = 8'h08;

    // Values after reset.
    localparam logic [7:0] RST_STEPDOWN1_LIMIT_AND_SLEW = 8'h1a;
    localparam logic [7:0] RST_STEPDOWN0_VOLTAGE_CODE = 8'h00;
    localparam logic [7:0] RST_STEPDOWN1_VOLTAGE_CODE = 8'h00;
    localparam logic [7:0] RST_BOOSTER_CONTROL = 8'h08;

    // Bits that a stored-default load replaces; the others keep their value.
    localparam logic [7:0] OTP_MASK_LIMIT_AND_SLEW = 8'h3f;
    localparam logic [7:0] OTP_MASK_VOLTAGE_CODE = 8'hff;
    localparam logic [7:0] OTP_MASK_BOOSTER_CONTROL = 8'hc7;

    // Field positions.
    localparam int ILIM_LSB = 3;
    localparam int SLEW_LSB = 0;
    localparam int BOOSTER_VOLTAGE_FIELD_LSB = 6;
    localparam int BOOST_DISCHARGE_BIT = 3;
    localparam int BOOST_PIN_SEL_LSB = 1;
    localparam int BOOST_ENABLE_BIT = 0;

    // Reserved codes of the narrow fields.
    localparam logic [2:0] ILIM_RESERVED_CODE = 3'h7;
    localparam logic [2:0] SLEW_FIRST_LEGAL = 3'h2;

    // Voltage code breakpoints and the millivolt value at each range start.
    localparam logic [7:0] VCODE_RANGE0_FIRST = 8'h14;
    localparam logic [7:0] VCODE_RANGE1_FIRST = 8'h18;
    localparam logic [7:0] VCODE_RANGE2_FIRST = 8'h9e;
    localparam logic [11:0] VOLT_RANGE0_BASE_MV = 12'd700;
    localparam logic [11:0] VOLT_RANGE1_BASE_MV = 12'd735;
    localparam logic [11:0] VOLT_RANGE2_BASE_MV = 12'd1420;
    localparam logic [11:0] VOLT_RANGE0_STEP_MV = 12'd10;
    localparam logic [11:0] VOLT_RANGE1_STEP_MV = 12'd5;
    localparam logic [11:0] VOLT_RANGE2_STEP_MV = 12'd20;

    // Boost output voltage: base and step in millivolts.
    localparam logic [12:0] BOOST_BASE_MV = 13'd4900;
    localparam logic [12:0] BOOST_STEP_MV = 13'd100;

    // Depth of the enable pin synchroniser.
    localparam int SYNC_STAGES = 2;

    // Pin select codes of the boost enable gating.
    typedef enum logic [1:0] {
        PIN_SEL_NONE,
        PIN_SEL_ONE,
        PIN_SEL_TWO,
        PIN_SEL_THREE
    } pin_sel_t;

    // One request on the register port.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // The stored defaults presented by the one-time-programmable memory.
    typedef struct packed {
        logic [7:0] limit_and_slew;
        logic [7:0] stepdown0_code;
        logic [7:0] stepdown1_code;
        logic [7:0] booster_control;
    } otp_image_t;

endpackage : regulator_output_control_pkg

// ---- verilog/enable_pin_sync.sv ----
/*
 * Multi-stage synchroniser for the external enable pins.
 * Assumes the pins are asynchronous levels; only the last stage is read.
 */
`timescale 1ns/1ps
`default_nettype none
module enable_pin_sync
    import regulator_output_control_pkg::*;
#(
    parameter int WIDTH = 3
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] pins_i,
    output logic [WIDTH-1:0] pins_sync_o
);

    // Stage chain; stage zero is read only by stage one.
    logic [WIDTH-1:0] stage_r [SYNC_STAGES];
    logic [WIDTH-1:0] stage_nxt [SYNC_STAGES];

    // Each stage takes the one before it.
    always_comb begin
        stage_nxt[0] = pins_i;
        for (int s = 1; s < SYNC_STAGES; s++) begin
            stage_nxt[s] = stage_r[s-1];
        end
    end

    // Stage registers clear to zero so no pin reads active out of reset.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int s = 0; s < SYNC_STAGES; s++) begin
                stage_r[s] <= '0;
            end
        end else begin
            for (int s = 0; s < SYNC_STAGES; s++) begin
                stage_r[s] <= stage_nxt[s]; // R17
            end
        end
    end

    assign pins_sync_o = stage_r[SYNC_STAGES-1];

endmodule : enable_pin_sync
`default_nettype wire

// ---- verilog/stepdown_voltage_decode.sv ----
/*
 * Registered decoder from a step-down voltage code to millivolts.
 * Assumes the code is a steady register value; result lags it by one clock.
 */
`timescale 1ns/1ps
`default_nettype none
module stepdown_voltage_decode
    import regulator_output_control_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] code_i,
    output logic [11:0] millivolt_o,
    output logic reserved_o
);

    // Decoded value and reserved flag, registered.
    logic [11:0] millivolt_r;
    logic [11:0] millivolt_nxt;
    logic reserved_r;
    logic reserved_nxt;

    // Pick the range of the code, then scale its offset by the range step.
    always_comb begin
        reserved_nxt = 1'b0;
        if (code_i >= VCODE_RANGE2_FIRST) begin
            millivolt_nxt = VOLT_RANGE2_BASE_MV
                + 12'(VOLT_RANGE2_STEP_MV * 12'(code_i - VCODE_RANGE2_FIRST)); // R8
        end else if (code_i >= VCODE_RANGE1_FIRST) begin
            millivolt_nxt = VOLT_RANGE1_BASE_MV
                + 12'(VOLT_RANGE1_STEP_MV * 12'(code_i - VCODE_RANGE1_FIRST)); // R7
        end else if (code_i >= VCODE_RANGE0_FIRST) begin
            millivolt_nxt = VOLT_RANGE0_BASE_MV
                + 12'(VOLT_RANGE0_STEP_MV * 12'(code_i - VCODE_RANGE0_FIRST)); // R6
        end else begin
            // Reserved codes give no setpoint; the flag tells the loop to hold off.
            millivolt_nxt = '0;
            reserved_nxt = 1'b1; // R5
        end
    end

    // Result register.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            millivolt_r <= '0;
            reserved_r <= 1'b1;
        end else begin
            millivolt_r <= millivolt_nxt;
            reserved_r <= reserved_nxt;
        end
    end

    assign millivolt_o = millivolt_r;
    assign reserved_o = reserved_r;

endmodule : stepdown_voltage_decode
`default_nettype wire

// ---- verilog/regulator_output_control_regs.sv ----
/*
 * Control registers for the second step-down converter's limit and slew,
 * both step-down voltage codes, and the boost converter.
 * Assumes a synchronous register port from the host bus front end, a stored
 * default load strobe from the one-time-programmable memory, and
 * asynchronous external enable pins.
 */
`timescale 1ns/1ps
`default_nettype none
module regulator_output_control_regs
    import regulator_output_control_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire reg_req_t reg_req_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    input wire logic otp_load_i,
    input wire otp_image_t otp_image_i,
    input wire logic enable_pin_one_i,
    input wire logic enable_pin_two_i,
    input wire logic enable_pin_three_i,
    output logic [2:0] stepdown1_peak_current_limit_o,
    output logic [2:0] stepdown1_slew_select_o,
    output logic stepdown1_limit_reserved_o,
    output logic stepdown1_slew_reserved_o,
    output logic [7:0] stepdown0_voltage_field_o,
    output logic [7:0] stepdown1_voltage_field_o,
    output logic [11:0] stepdown0_millivolt_o,
    output logic [11:0] stepdown1_millivolt_o,
    output logic stepdown0_code_reserved_o,
    output logic stepdown1_code_reserved_o,
    output logic [1:0] booster_voltage_field_o,
    output logic [12:0] booster_millivolt_o,
    output logic booster_enable_o,
    output logic booster_enable_rise_o,
    output logic booster_enable_fall_o,
    output logic booster_discharge_o
);

    // Software-visible registers.
    logic [7:0] limit_and_slew_r;
    logic [7:0] limit_and_slew_nxt;
    logic [7:0] stepdown0_code_r;
    logic [7:0] stepdown0_code_nxt;
    logic [7:0] stepdown1_code_r;
    logic [7:0] stepdown1_code_nxt;
    logic [7:0] booster_control_r;
    logic [7:0] booster_control_nxt;

    // Read data path.
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;

    // Boost decision and its previous value for edge detection.
    logic enable_r;
    logic enable_nxt;
    logic discharge_r;
    logic discharge_nxt;
    logic rise_r;
    logic rise_nxt;
    logic fall_r;
    logic fall_nxt;

    // Synchronised enable pins, bit zero is pin one.
    logic [2:0] pins_sync;
    pin_sel_t pin_sel;
    logic pin_gate;

    // Merges a write or stored-default load into a register; load wins.
    function automatic logic [7:0] merge(input logic [7:0] cur, input logic hit,
                                         input logic [7:0] wdata, input logic [7:0] img,
                                         input logic [7:0] mask);
        logic [7:0] val;
        val = hit ? wdata : cur;
        if (otp_load_i) begin
            val = (cur & ~mask) | (img & mask);
        end
        return val;
    endfunction : merge

    // Register image at an offset; unmapped offsets read as zero.
    function automatic logic [7:0] read_mux(input logic [7:0] addr);
        logic [7:0] val;
        val = 8'h00;
        unique case (addr)
            OFS_STEPDOWN1_LIMIT_AND_SLEW: val = limit_and_slew_r;
            OFS_STEPDOWN0_VOLTAGE_CODE: val = stepdown0_code_r;
            OFS_STEPDOWN1_VOLTAGE_CODE: val = stepdown1_code_r;
            OFS_BOOSTER_CONTROL: val = booster_control_r;
            default: val = 8'h00;
        endcase
        return val;
    endfunction : read_mux

    // Bring the three pins into the clock domain before they gate anything.
    enable_pin_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .pins_i({enable_pin_three_i, enable_pin_two_i, enable_pin_one_i}),
        .pins_sync_o(pins_sync)
    ); // R17

    // The two step-down converters share one mapping through two decoders.
    stepdown_voltage_decode u_decode0 (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .code_i(stepdown0_code_r),
        .millivolt_o(stepdown0_millivolt_o),
        .reserved_o(stepdown0_code_reserved_o)
    ); // R9

    stepdown_voltage_decode u_decode1 (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .code_i(stepdown1_code_r),
        .millivolt_o(stepdown1_millivolt_o),
        .reserved_o(stepdown1_code_reserved_o)
    ); // R9

    // Register writes; each offset touches its own register only.
    always_comb begin
        limit_and_slew_nxt = merge(limit_and_slew_r,
            reg_req_i.wr && reg_req_i.addr == OFS_STEPDOWN1_LIMIT_AND_SLEW,
            reg_req_i.wdata, otp_image_i.limit_and_slew, OTP_MASK_LIMIT_AND_SLEW); // R2
        stepdown0_code_nxt = merge(stepdown0_code_r,
            reg_req_i.wr && reg_req_i.addr == OFS_STEPDOWN0_VOLTAGE_CODE,
            reg_req_i.wdata, otp_image_i.stepdown0_code, OTP_MASK_VOLTAGE_CODE); // R15
        stepdown1_code_nxt = merge(stepdown1_code_r,
            reg_req_i.wr && reg_req_i.addr == OFS_STEPDOWN1_VOLTAGE_CODE,
            reg_req_i.wdata, otp_image_i.stepdown1_code, OTP_MASK_VOLTAGE_CODE); // R9
        booster_control_nxt = merge(booster_control_r,
            reg_req_i.wr && reg_req_i.addr == OFS_BOOSTER_CONTROL,
            reg_req_i.wdata, otp_image_i.booster_control, OTP_MASK_BOOSTER_CONTROL);
    end

    // Registers take the documented reset values, stored defaults come later.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            limit_and_slew_r <= RST_STEPDOWN1_LIMIT_AND_SLEW; // R4
            stepdown0_code_r <= RST_STEPDOWN0_VOLTAGE_CODE; // R15
            stepdown1_code_r <= RST_STEPDOWN1_VOLTAGE_CODE;
            booster_control_r <= RST_BOOSTER_CONTROL; // R14
        end else begin
            limit_and_slew_r <= limit_and_slew_nxt;
            stepdown0_code_r <= stepdown0_code_nxt;
            stepdown1_code_r <= stepdown1_code_nxt;
            booster_control_r <= booster_control_nxt;
        end
    end

    // Read answers one clock after the request.
    always_comb begin
        rvalid_nxt = reg_req_i.rd;
        rdata_nxt = reg_req_i.rd ? read_mux(reg_req_i.addr) : rdata_r;
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // Pin gating: select code picks which synchronised pin must be high.
    assign pin_sel = pin_sel_t'(booster_control_r[BOOST_PIN_SEL_LSB +: 2]);

    always_comb begin
        unique case (pin_sel)
            PIN_SEL_NONE: pin_gate = 1'b1;
            PIN_SEL_ONE: pin_gate = pins_sync[0];
            PIN_SEL_TWO: pin_gate = pins_sync[1];
            PIN_SEL_THREE: pin_gate = pins_sync[2];
        endcase
    end

    // Combined enable, discharge control, and edge pulses for the delay timers.
    always_comb begin
        enable_nxt = booster_control_r[BOOST_ENABLE_BIT] && pin_gate; // R12 R13
        discharge_nxt = booster_control_r[BOOST_DISCHARGE_BIT] && !enable_nxt; // R11
        rise_nxt = enable_nxt && !enable_r; // R16
        fall_nxt = !enable_nxt && enable_r; // R16
    end

    // The enable starts low so no edge is reported at reset release.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            enable_r <= 1'b0;
            discharge_r <= 1'b1;
            rise_r <= 1'b0;
            fall_r <= 1'b0;
        end else begin
            enable_r <= enable_nxt;
            discharge_r <= discharge_nxt;
            rise_r <= rise_nxt;
            fall_r <= fall_nxt;
        end
    end

    // Setpoint outputs straight from the registers so writes act at once.
    assign stepdown1_peak_current_limit_o = limit_and_slew_r[ILIM_LSB +: 3]; // R1
    assign stepdown1_slew_select_o = limit_and_slew_r[SLEW_LSB +: 3]; // R3
    assign stepdown1_limit_reserved_o = (stepdown1_peak_current_limit_o == ILIM_RESERVED_CODE);
    assign stepdown1_slew_reserved_o = (stepdown1_slew_select_o < SLEW_FIRST_LEGAL);
    assign stepdown0_voltage_field_o = stepdown0_code_r;
    assign stepdown1_voltage_field_o = stepdown1_code_r;
    assign booster_voltage_field_o = booster_control_r[BOOSTER_VOLTAGE_FIELD_LSB +: 2]; // R10
    assign booster_millivolt_o = BOOST_BASE_MV
        + 13'(BOOST_STEP_MV * 13'(booster_voltage_field_o)); // R10
    assign booster_enable_o = enable_r;
    assign booster_discharge_o = discharge_r;
    assign booster_enable_rise_o = rise_r;
    assign booster_enable_fall_o = fall_r;
    assign rdata_o = rdata_r;
    assign rvalid_o = rvalid_r;

    // Checks on the behaviour above.
    logic pin1_gate_ok;
    assign pin1_gate_ok = booster_control_r[BOOST_ENABLE_BIT] && pin_sel == PIN_SEL_ONE
        && enable_pin_one_i;

    property p_reset_values;
        @(posedge core_clk_i) $fell(rst_i) |-> limit_and_slew_r == 8'h1a
            && booster_control_r == 8'h08 && stepdown0_code_r == 8'h00;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("bad reset values"); // R4

    property p_limit_write;
        @(posedge core_clk_i) disable iff (rst_i)
        reg_req_i.wr && reg_req_i.addr == 8'h05 && !otp_load_i
            |=> stepdown1_peak_current_limit_o == $past(reg_req_i.wdata[5:3])
                && stepdown1_slew_select_o == $past(reg_req_i.wdata[2:0]);
    endproperty
    a_limit_write: assert property (p_limit_write) else $error("limit write lost"); // R2

    property p_code_isolated;
        @(posedge core_clk_i) disable iff (rst_i)
        reg_req_i.wr && reg_req_i.addr == 8'h07 && !otp_load_i
            |=> $stable(stepdown0_code_r) && stepdown1_code_r == $past(reg_req_i.wdata);
    endproperty
    a_code_isolated: assert property (p_code_isolated) else $error("codes not separate"); // R9

    property p_decode_low;
        @(posedge core_clk_i) disable iff (rst_i)
        stepdown0_code_r == 8'h17 |=> stepdown0_millivolt_o == 12'd730;
    endproperty
    a_decode_low: assert property (p_decode_low) else $error("0x17 not 730 mV"); // R6

    property p_decode_mid;
        @(posedge core_clk_i) disable iff (rst_i)
        stepdown0_code_r == 8'h9d |=> stepdown0_millivolt_o == 12'd1400;
    endproperty
    a_decode_mid: assert property (p_decode_mid) else $error("0x9d not 1400 mV"); // R7

    property p_decode_high;
        @(posedge core_clk_i) disable iff (rst_i)
        stepdown1_code_r == 8'hff |=> stepdown1_millivolt_o == 12'd3360;
    endproperty
    a_decode_high: assert property (p_decode_high) else $error("0xff not 3360 mV"); // R8

    property p_enable_off;
        @(posedge core_clk_i) disable iff (rst_i)
        !booster_control_r[0] |=> !booster_enable_o;
    endproperty
    a_enable_off: assert property (p_enable_off) else $error("boost on without bit"); // R13

    property p_pin_latency;
        @(posedge core_clk_i) disable iff (rst_i)
        $rose(enable_pin_one_i) && pin1_gate_ok ##1 pin1_gate_ok [*2] |=> booster_enable_o;
    endproperty
    a_pin_latency: assert property (p_pin_latency) else $error("pin gate too slow"); // R17

    property p_discharge;
        @(posedge core_clk_i) disable iff (rst_i)
        ##1 booster_discharge_o == (booster_control_r[3] && !booster_enable_o)
            || $changed(booster_control_r);
    endproperty
    a_discharge: assert property (p_discharge) else $error("discharge mismatch"); // R11

    property p_rise_pulse;
        @(posedge core_clk_i) disable iff (rst_i)
        $rose(booster_enable_o) |-> booster_enable_rise_o ##1 !booster_enable_rise_o;
    endproperty
    a_rise_pulse: assert property (p_rise_pulse) else $error("no rise pulse"); // R16

    c_boost_on: cover property (@(posedge core_clk_i) disable iff (rst_i)
        $rose(booster_enable_o));
    c_boost_off: cover property (@(posedge core_clk_i) disable iff (rst_i)
        booster_enable_fall_o);
    c_otp_load: cover property (@(posedge core_clk_i) disable iff (rst_i) otp_load_i);
    c_read: cover property (@(posedge core_clk_i) disable iff (rst_i)
        rvalid_o && rdata_o != 8'h00);

endmodule : regulator_output_control_regs
`default_nettype wire

// ---- verification/host_model.sv ----
/*
 * Host processor model: drives the register port, stored-default loads and enable pins.
 * Assumes one bench process calls its tasks; every change lands on a falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module host_model
    import regulator_output_control_pkg::*;
(
    input wire logic core_clk_i,
    output var reg_req_t reg_req_o,
    output logic otp_load_o,
    output var otp_image_t otp_image_o,
    output logic [2:0] pins_o
);
    logic [7:0] exp_q[$]; // Expected read data, oldest first.

    // Idle values from time zero.
    initial begin
        reg_req_o = '0;
        otp_load_o = 1'b0;
        otp_image_o = '0;
        pins_o = 3'h0;
    end

    // One access held for one rising edge; a released bus shows inverted values.
    task automatic access(input logic w, input logic r, input logic [7:0] a,
                          input logic [7:0] d, input logic [7:0] e);
        @(negedge core_clk_i);
        reg_req_o = '{wr: w, rd: r, addr: a, wdata: d};
        if (r) begin
            exp_q.push_back(e);
        end
        @(negedge core_clk_i);
        reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : access

    // One stored-default load strobe with its image.
    task automatic otp_load(input otp_image_t img);
        @(negedge core_clk_i);
        otp_load_o = 1'b1;
        otp_image_o = img;
        @(negedge core_clk_i);
        otp_load_o = 1'b0;
        otp_image_o = ~img;
    endtask : otp_load

    // New external enable pin levels.
    task automatic set_pins(input logic [2:0] p);
        @(negedge core_clk_i);
        pins_o = p;
    endtask : set_pins
endmodule : host_model
`default_nettype wire

// ---- verification/test_regulator_output_control_regs.sv ----
/*
 * Self-checking bench for the converter output control register bank.
 * Assumes the host model drives all inputs but clock and reset; reads are checked from a queue.
 */
`timescale 1ns/1ps
`default_nettype none
module test_regulator_output_control_regs
    import regulator_output_control_pkg::*;
;
    logic core_clk_i, rst_i, rvalid, otp_load, lim_res, slew_res, res0, res1;
    logic en, rise, fall, dis;
    reg_req_t req;
    otp_image_t img;
    logic [2:0] pins, ilim, slew;
    logic [7:0] rdata, f0, f1, c0, c1, ctrl;
    logic [11:0] mv0, mv1;
    logic [1:0] bv;
    logic [12:0] bmv;
    logic [7:0] bnd [6] = '{8'h14, 8'h17, 8'h18, 8'h9d, 8'h9e, 8'hff};
    logic exp_en;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed = 93;

    host_model u_host_model (.core_clk_i(core_clk_i), .reg_req_o(req), .otp_load_o(otp_load),
        .otp_image_o(img), .pins_o(pins));
    regulator_output_control_regs u_regulator_output_control_regs (.core_clk_i(core_clk_i),
        .rst_i(rst_i), .reg_req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
        .otp_load_i(otp_load), .otp_image_i(img), .enable_pin_one_i(pins[0]),
        .enable_pin_two_i(pins[1]), .enable_pin_three_i(pins[2]),
        .stepdown1_peak_current_limit_o(ilim), .stepdown1_slew_select_o(slew),
        .stepdown1_limit_reserved_o(lim_res), .stepdown1_slew_reserved_o(slew_res),
        .stepdown0_voltage_field_o(f0), .stepdown1_voltage_field_o(f1),
        .stepdown0_millivolt_o(mv0), .stepdown1_millivolt_o(mv1),
        .stepdown0_code_reserved_o(res0), .stepdown1_code_reserved_o(res1),
        .booster_voltage_field_o(bv), .booster_millivolt_o(bmv), .booster_enable_o(en),
        .booster_enable_rise_o(rise), .booster_enable_fall_o(fall), .booster_discharge_o(dis));

    // Free-running 40 MHz clock.
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    // Compares one value and counts the outcome.
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    // Expected millivolts of a legal step-down code.
    function automatic logic [11:0] mv_of(input logic [7:0] c);
        int v;
        v = int'(c);
        if (v < 24) return 12'(700 + 10 * (v - 20));
        if (v < 158) return 12'(735 + 5 * (v - 24));
        return 12'(1420 + 20 * (v - 158));
    endfunction : mv_of

    // Each read answer is matched against the oldest noted expectation.
    always @(negedge core_clk_i) begin
        if (rvalid === 1'b1) begin
            if (u_host_model.exp_q.size() > 0) begin
                check("rdata", {8'h00, rdata}, {8'h00, u_host_model.exp_q.pop_front()});
            end else begin
                check("unexpected rvalid", 16'h1, 16'h0);
            end
        end
    end

    // A hang counts as a failure and ends the run.
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            summarize();
        end
    end

    initial begin
        rst_i = 1'b1;
        repeat (5) @(negedge core_clk_i);
        rst_i = 1'b0;
        check("reset outputs", {dis, res0, res1, en, mv0}, 16'he000);
        u_host_model.access(1'b0, 1'b1, 8'h05, 8'h00, 8'h1a);
        u_host_model.access(1'b0, 1'b1, 8'h06, 8'h00, 8'h00);
        u_host_model.access(1'b0, 1'b1, 8'h07, 8'h00, 8'h00);
        u_host_model.access(1'b0, 1'b1, 8'h08, 8'h00, 8'h08);
        u_host_model.access(1'b1, 1'b0, 8'h09, 8'hff, 8'h00);
        u_host_model.access(1'b0, 1'b1, 8'h09, 8'h00, 8'h00);
        $display("test reset values done");
        // Every limit and slew code, reserved ones included, with an idle cycle between writes.
        for (int i = 0; i < 8; i++) begin
            u_host_model.access(1'b1, 1'b0, 8'h05, {2'b00, 3'(i), 3'(7 - i)}, 8'h00);
            check("limit", 16'(ilim), 16'(i));
            check("slew", 16'(slew), 16'(7 - i));
            check("limit flag", 16'(lim_res), 16'(i == 7));
            check("slew flag", 16'(slew_res), 16'(i > 5));
        end
        u_host_model.access(1'b0, 1'b1, 8'h05, 8'h00, 8'h38);
        $display("test limit and slew done");
        // Range edges first, then random legal codes for both converters.
        for (int i = 0; i < 16; i++) begin
            c0 = (i < 6) ? bnd[i] : 8'h14 + 8'($unsigned($random(seed)) % 236);
            c1 = 8'hff - c0 + 8'h14;
            u_host_model.access(1'b1, 1'b0, 8'h06, c0, 8'h00);
            u_host_model.access(1'b1, 1'b0, 8'h07, c1, 8'h00);
            @(negedge core_clk_i);
            check("mv0", 16'(mv0), 16'(mv_of(c0)));
            check("mv1", 16'(mv1), 16'(mv_of(c1)));
            check("fields", {f0, f1}, {c0, c1});
            check("code flags", {14'h0, res0, res1}, 16'h0);
        end
        u_host_model.access(1'b0, 1'b1, 8'h06, 8'h00, c0);
        $display("test voltage codes done");
        // Every boost setting against random levels on pins two and three, pin one from k; reserved bits kept at reset.
        for (int k = 0; k < 64; k++) begin
            ctrl = {2'(k >> 4), 2'b00, 4'(k)};
            u_host_model.access(1'b1, 1'b0, 8'h08, ctrl, 8'h00);
            u_host_model.set_pins({2'($random(seed)), 1'(k[3] ^ k[0])});
            repeat (3) @(negedge core_clk_i);
            exp_en = ctrl[0] & ((ctrl[2:1] == 2'h0) | pins[ctrl[2:1] - 2'h1]);
            check("boost enable", 16'(en), 16'(exp_en));
            check("discharge", 16'(dis), 16'(ctrl[3] & ~exp_en));
            check("boost mv", 16'(bmv), 16'(4900 + 100 * (k >> 4)));
            check("boost field", 16'(bv), 16'(k >> 4));
        end
        $display("test boost control done");
        // Enable edges by register write give one-cycle pulses.
        u_host_model.access(1'b1, 1'b0, 8'h08, 8'h08, 8'h00);
        repeat (2) @(negedge core_clk_i);
        u_host_model.access(1'b1, 1'b0, 8'h08, 8'h01, 8'h00);
        @(negedge core_clk_i);
        check("rise pulse", {14'h0, rise, en}, 16'h3);
        @(negedge core_clk_i);
        check("rise ends", 16'(rise), 16'h0);
        u_host_model.access(1'b1, 1'b0, 8'h08, 8'h08, 8'h00);
        @(negedge core_clk_i);
        check("fall pulse", {14'h0, fall, en}, 16'h2);
        $display("test enable edges done");
        // Stored defaults replace only their own bits; then write and read together.
        u_host_model.otp_load('{8'hff, 8'h33, 8'h9e, 8'hff});
        u_host_model.access(1'b0, 1'b1, 8'h05, 8'h00, 8'h3f);
        u_host_model.access(1'b0, 1'b1, 8'h06, 8'h00, 8'h33);
        u_host_model.access(1'b0, 1'b1, 8'h07, 8'h00, 8'h9e);
        u_host_model.access(1'b1, 1'b1, 8'h08, 8'h41, 8'hcf);
        u_host_model.access(1'b0, 1'b1, 8'h08, 8'h00, 8'h41);
        repeat (3) @(negedge core_clk_i);
        check("reads pending", 16'(u_host_model.exp_q.size()), 16'h0);
        $display("test stored defaults done");
        summarize();
    end
endmodule : test_regulator_output_control_regs
`default_nettype wire
